// ==== src/adcsq_top.sv ====
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// - three-bit field picks both converter references
// - calibration grounds inputs, opens every switch
// - calibration overrides pin and channel settings
// - scan enable walks mask, else fixed channel
// - interrupt after field plus one sequences
// - alternate mode: A first, then B/A
// - clock source bit picks RC or divider
// - divided period is cycle times field plus one
// - mux B code selects channel in binary
// - band gap offered only while enabled
// - results go to two-word buffer
// - four result alignments, zero-filled integer default
module adcsq_top #(
   parameter int TCY_CLKS = adcsq_pkg::TCY_SYS_CLKS
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcsq_pkg::ADDR_W-1:0] paddr,
   input wire logic [adcsq_pkg::DATA_W-1:0] pwdata,
   output logic pready,
   output logic [adcsq_pkg::DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic rcClockPin,
   input wire logic convDonePin,
   input wire logic [adcsq_pkg::RES_W-1:0] convResult,
   output logic refPosExternal,
   output logic refNegExternal,
   output logic inputsGrounded,
   output logic [adcsq_pkg::CH_W-1:0] muxPosChannel,
   output logic muxNegAn1,
   output logic bandgapToConverter,
   output logic chargePumpEnable,
   output logic convClkFromRc,
   output logic convClkTick,
   output logic sampleStart,
   output logic adcInterrupt
);
   // local names for package items used as cast widths and state labels
   localparam int DATA_W = adcsq_pkg::DATA_W;
   localparam int DIV_W = adcsq_pkg::DIV_W;
   localparam adcsq_pkg::adcsq_state_e ST_IDLE = adcsq_pkg::ST_IDLE;
   localparam adcsq_pkg::adcsq_state_e ST_CONVERT = adcsq_pkg::ST_CONVERT;
   // field widths inside the control words
   localparam int REFSEL_W = 3;
   localparam int SEQPI_W = 4;
   localparam int FORMAT_W = 2;

   typedef struct packed {
      logic [adcsq_pkg::REG_W-1:0] conOne;
      logic [adcsq_pkg::REG_W-1:0] conTwo;
      logic [adcsq_pkg::REG_W-1:0] timing;
      logic [adcsq_pkg::REG_W-1:0] chanSel;
      logic [adcsq_pkg::REG_W-1:0] scanSel;
      logic [adcsq_pkg::REG_W-1:0] analog_input_config;
      logic [adcsq_pkg::BUF_DEPTH-1:0][adcsq_pkg::RES_W-1:0] resBuf;
      logic wrIdx;
      logic [SEQPI_W-1:0] seqCnt;
      logic [adcsq_pkg::CH_W-1:0] scanPtr;
      logic altB;
      adcsq_pkg::adcsq_state_e state;
      logic startPend;
      logic seqDone;
      logic [adcsq_pkg::DIV_W-1:0] divCnt;
      logic [adcsq_pkg::SYNC_LEN-1:0] doneSync;
      logic doneLvl;
      logic [adcsq_pkg::SYNC_LEN-1:0] rcSync;
      logic rcLvl;
      logic pready;
      logic [adcsq_pkg::DATA_W-1:0] prdata;
      logic pslverr;
      logic refPosExt;
      logic refNegExt;
      logic grounded;
      logic [adcsq_pkg::CH_W-1:0] muxPos;
      logic muxNegAn1;
      logic bandgapOn;
      logic pumpOn;
      logic clkFromRc;
      logic clkTick;
      logic sampleStart;
      logic irq;
   } adcsq_state_s;

   adcsq_state_s s_q;
   adcsq_state_s s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // first selected channel at or above start, wrapping round
   function automatic logic [adcsq_pkg::CH_W-1:0] pickFrom(
      input logic [adcsq_pkg::REG_W-1:0] mask,
      input logic [adcsq_pkg::CH_W-1:0] start
   );
      logic [adcsq_pkg::CH_W-1:0] idx;
      logic found;
      pickFrom = start;
      found = 1'b0;
      for (int i = 0; i < adcsq_pkg::NUM_CH; i++) begin
         idx = start + i[adcsq_pkg::CH_W-1:0];
         if (!found && mask[idx]) begin
            pickFrom = idx;
            found = 1'b1;
         end
      end
   endfunction

   function automatic logic [adcsq_pkg::REG_W-1:0] formatResult(
      input logic [adcsq_pkg::RES_W-1:0] d,
      input logic [1:0] result_format
   );
      case (result_format)
         adcsq_pkg::FMT_INTEGER: formatResult = {6'h00, d};
         adcsq_pkg::FMT_SIGNED_INTEGER: formatResult = {{7{~d[9]}}, d[8:0]};
         adcsq_pkg::FMT_FRACTION: formatResult = {d, 6'h00};
         default: formatResult = {~d[9], d[8:0], 6'h00};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   logic setupPhase;
   logic writeAccess;
   logic doneRise;
   logic rcRise;
   logic [adcsq_pkg::DIV_W-1:0] tadClks;
   logic [adcsq_pkg::CH_W-1:0] scanChan;
   logic [adcsq_pkg::CH_W-1:0] sampleChan;
   logic [adcsq_pkg::REG_W-1:0] rdVal;
   logic [adcsq_pkg::REG_W-1:0] wd;
   logic [REFSEL_W-1:0] refSel;
   logic offset_calibrate;
   logic scanEn;
   logic altEn;
   logic [SEQPI_W-1:0] seqPerIrq;
   logic [FORMAT_W-1:0] result_format;
   logic mapped;
   logic seqEnd;

   always_comb begin
      s_d = s_q;
      wd = pwdata[adcsq_pkg::REG_W-1:0];
      refSel = s_q.conTwo[adcsq_pkg::REFSEL_LO +: REFSEL_W];
      offset_calibrate = s_q.conTwo[adcsq_pkg::BIT_OFFSET_CALIBRATE];
      scanEn = s_q.conTwo[adcsq_pkg::BIT_SCAN_ENABLE_MUX_A];
      altEn = s_q.conTwo[adcsq_pkg::BIT_ALTERNATE_MUX_SAMPLE];
      seqPerIrq = s_q.conTwo[adcsq_pkg::SEQPI_LO +: SEQPI_W];
      result_format = s_q.conOne[adcsq_pkg::FORMAT_LO +: FORMAT_W];
      setupPhase = psel && !penable;
      writeAccess = psel && penable && s_q.pready && pwrite;

      // external levels: three stages, accepted when last two agree
      s_d.doneSync = {s_q.doneSync[1:0], convDonePin};
      s_d.rcSync = {s_q.rcSync[1:0], rcClockPin};
      if (s_q.doneSync[1] == s_q.doneSync[2]) begin
         s_d.doneLvl = s_q.doneSync[2];
      end
      if (s_q.rcSync[1] == s_q.rcSync[2]) begin
         s_d.rcLvl = s_q.rcSync[2];
      end
      doneRise = s_d.doneLvl && !s_q.doneLvl;
      rcRise = s_d.rcLvl && !s_q.rcLvl;

      // conversion clock
      tadClks = DIV_W'(TCY_CLKS) *
                (DIV_W'(s_q.timing[adcsq_pkg::CLKDIV_LO +: adcsq_pkg::CLKDIV_W]) + 8'h01);
      s_d.clkFromRc = s_q.timing[adcsq_pkg::BIT_CLOCK_SOURCE];
      s_d.clkTick = 1'b0;
      if (s_q.timing[adcsq_pkg::BIT_CLOCK_SOURCE]) begin
         s_d.divCnt = '0;
         s_d.clkTick = rcRise;
      end else if (s_q.divCnt >= tadClks - 8'h01) begin
         s_d.divCnt = '0;
         s_d.clkTick = 1'b1;
      end else begin
         s_d.divCnt = s_q.divCnt + 8'h01;
      end

      // references
      s_d.refPosExt = !refSel[2] && refSel[0];
      s_d.refNegExt = !refSel[2] && refSel[1];

      // channel for the coming sample
      scanChan = pickFrom(s_q.scanSel, s_q.scanPtr);
      if (altEn && s_q.altB) begin
         sampleChan = s_q.chanSel[adcsq_pkg::MUX_B_POS_LO +: adcsq_pkg::CH_W];
      end else if (scanEn) begin
         sampleChan = scanChan;
      end else begin
         sampleChan = s_q.chanSel[adcsq_pkg::MUX_A_POS_LO +: adcsq_pkg::CH_W];
      end
      s_d.grounded = offset_calibrate;
      s_d.muxPos = offset_calibrate ? '0 : sampleChan;
      s_d.muxNegAn1 = !offset_calibrate && s_q.chanSel[adcsq_pkg::BIT_MUX_A_NEG];
      s_d.bandgapOn = !offset_calibrate && s_q.analog_input_config[adcsq_pkg::BIT_BANDGAP_ENABLE] &&
                      sampleChan == adcsq_pkg::BANDGAP_CHANNEL;
      s_d.pumpOn = s_q.timing[adcsq_pkg::BIT_CHARGE_PUMP];

      // sequencing
      s_d.sampleStart = 1'b0;
      s_d.irq = 1'b0;
      // a finished conversion counts only while the module stays on
      seqEnd = s_q.state == ST_CONVERT && s_q.conOne[adcsq_pkg::BIT_MODULE_ON] && doneRise;
      case (s_q.state)
         ST_IDLE: begin
            if (s_q.startPend && s_q.conOne[adcsq_pkg::BIT_MODULE_ON]) begin
               s_d.startPend = 1'b0;
               s_d.sampleStart = 1'b1;
               s_d.state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (!s_q.conOne[adcsq_pkg::BIT_MODULE_ON]) begin
               s_d.state = ST_IDLE;
            end else if (doneRise) begin
               s_d.resBuf[s_q.wrIdx] = convResult;
               s_d.wrIdx = !s_q.wrIdx;
               s_d.seqDone = 1'b1;
               s_d.altB = altEn && !s_q.altB;
               if (scanEn && !(altEn && s_q.altB)) begin
                  s_d.scanPtr = scanChan + 4'h1;
               end
               if (s_q.seqCnt >= seqPerIrq) begin
                  s_d.irq = 1'b1;
                  s_d.seqCnt = '0;
                  s_d.wrIdx = 1'b0;
                  s_d.scanPtr = '0;
                  s_d.altB = 1'b0;
               end else begin
                  s_d.seqCnt = s_q.seqCnt + 4'h1;
               end
               s_d.state = ST_IDLE;
            end
         end
         default: s_d.state = ST_IDLE;
      endcase

      // register read value
      mapped = 1'b1;
      case (paddr)
         adcsq_pkg::OFS_CONTROL_ONE: rdVal = s_q.conOne;
         adcsq_pkg::OFS_CONTROL_TWO: rdVal = s_q.conTwo;
         adcsq_pkg::OFS_TIMING_CONTROL: rdVal = s_q.timing;
         adcsq_pkg::OFS_CHANNEL_SELECT: rdVal = s_q.chanSel;
         adcsq_pkg::OFS_SCAN_SELECT: rdVal = s_q.scanSel;
         adcsq_pkg::OFS_ANALOG_INPUT_CONFIG: rdVal = s_q.analog_input_config;
         adcsq_pkg::OFS_RESULT_ZERO: rdVal = formatResult(s_q.resBuf[0], result_format);
         adcsq_pkg::OFS_RESULT_ONE: rdVal = formatResult(s_q.resBuf[1], result_format);
         adcsq_pkg::OFS_STATUS: begin
            rdVal = '0;
            rdVal[adcsq_pkg::BIT_BUSY] = s_q.state == ST_CONVERT || s_q.startPend;
            rdVal[adcsq_pkg::BIT_WRITE_INDEX] = s_q.wrIdx;
            rdVal[adcsq_pkg::SEQCNT_LO +: SEQPI_W] = s_q.seqCnt;
            rdVal[adcsq_pkg::BIT_SEQ_DONE] = s_q.seqDone;
         end
         default: begin
            rdVal = '0;
            mapped = 1'b0;
         end
      endcase

      // apb: ready in the first access cycle
      if (setupPhase) begin
         s_d.pready = 1'b1;
         s_d.prdata = pwrite ? '0 : DATA_W'(rdVal);
         s_d.pslverr = !mapped;
      end else begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
      if (writeAccess && mapped) begin
         case (paddr)
            adcsq_pkg::OFS_CONTROL_ONE: begin
               s_d.conOne = wd & adcsq_pkg::WMASK_CONTROL_ONE;
               if (wd[adcsq_pkg::BIT_START]) begin
                  s_d.startPend = 1'b1;
               end
               if (!wd[adcsq_pkg::BIT_MODULE_ON]) begin
                  s_d.startPend = 1'b0;
                  s_d.seqCnt = '0;
                  s_d.wrIdx = 1'b0;
                  s_d.scanPtr = '0;
                  s_d.altB = 1'b0;
               end
            end
            adcsq_pkg::OFS_CONTROL_TWO: s_d.conTwo = wd & adcsq_pkg::WMASK_CONTROL_TWO;
            adcsq_pkg::OFS_TIMING_CONTROL: s_d.timing = wd & adcsq_pkg::WMASK_TIMING_CONTROL;
            adcsq_pkg::OFS_CHANNEL_SELECT: s_d.chanSel = wd & adcsq_pkg::WMASK_CHANNEL_SELECT;
            adcsq_pkg::OFS_SCAN_SELECT: s_d.scanSel = wd & adcsq_pkg::WMASK_SCAN_SELECT;
            adcsq_pkg::OFS_ANALOG_INPUT_CONFIG: begin
               s_d.analog_input_config = wd & adcsq_pkg::WMASK_ANALOG_INPUT_CONFIG;
            end
            adcsq_pkg::OFS_STATUS: begin
               // write one clears; a completion in the same cycle wins
               if (wd[adcsq_pkg::BIT_SEQ_DONE] && !seqEnd) begin
                  s_d.seqDone = 1'b0;
               end
            end
            default: s_d.seqDone = s_d.seqDone;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.state <= ST_IDLE;
         s_q.conOne <= adcsq_pkg::RESET_VALUE;
         s_q.conTwo <= adcsq_pkg::RESET_VALUE;
         s_q.timing <= adcsq_pkg::RESET_VALUE;
      end else begin
         s_q <= s_d;
      end
   end

   assign pready = s_q.pready;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;
   assign refPosExternal = s_q.refPosExt;
   assign refNegExternal = s_q.refNegExt;
   assign inputsGrounded = s_q.grounded;
   assign muxPosChannel = s_q.muxPos;
   assign muxNegAn1 = s_q.muxNegAn1;
   assign bandgapToConverter = s_q.bandgapOn;
   assign chargePumpEnable = s_q.pumpOn;
   assign convClkFromRc = s_q.clkFromRc;
   assign convClkTick = s_q.clkTick;
   assign sampleStart = s_q.sampleStart;
   assign adcInterrupt = s_q.irq;
endmodule

// ==== src/adcsq_pkg.sv ====
package adcsq_pkg;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int RES_W = 10;
   localparam int ADDR_W = 8;
   localparam int CH_W = 4;
   localparam int NUM_CH = 16;
   localparam int BUF_DEPTH = 2;
   localparam int DIV_W = 8;
   localparam int SYNC_LEN = 3;
   localparam int TCY_SYS_CLKS = 2;

   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TIMING_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CHANNEL_SELECT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SCAN_SELECT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ANALOG_INPUT_CONFIG = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RESULT_ZERO = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_RESULT_ONE = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

   localparam logic [REG_W-1:0] WMASK_CONTROL_ONE = 16'h8300;
   localparam logic [REG_W-1:0] WMASK_CONTROL_TWO = 16'hF43D;
   localparam logic [REG_W-1:0] WMASK_TIMING_CONTROL = 16'hBF3F;
   localparam logic [REG_W-1:0] WMASK_CHANNEL_SELECT = 16'h8F8F;
   localparam logic [REG_W-1:0] WMASK_SCAN_SELECT = 16'hFFDF;
   localparam logic [REG_W-1:0] WMASK_ANALOG_INPUT_CONFIG = 16'h0001;
   localparam logic [REG_W-1:0] RESET_VALUE = 16'h0000;

   // control one
   localparam int BIT_MODULE_ON = 15;
   localparam int FORMAT_LO = 8;
   localparam int BIT_START = 0;
   // control two
   localparam int REFSEL_LO = 13;
   localparam int BIT_OFFSET_CALIBRATE = 12;
   localparam int BIT_SCAN_ENABLE_MUX_A = 10;
   localparam int SEQPI_LO = 2;
   localparam int BIT_ALTERNATE_MUX_SAMPLE = 0;
   // timing control
   localparam int BIT_CLOCK_SOURCE = 15;
   localparam int BIT_CHARGE_PUMP = 13;
   localparam int CLKDIV_LO = 0;
   localparam int CLKDIV_W = 6;
   // channel select
   localparam int MUX_B_POS_LO = 8;
   localparam int BIT_MUX_A_NEG = 7;
   localparam int MUX_A_POS_LO = 0;
   // analog input config
   localparam int BIT_BANDGAP_ENABLE = 0;
   // status
   localparam int BIT_BUSY = 0;
   localparam int BIT_WRITE_INDEX = 1;
   localparam int SEQCNT_LO = 2;
   localparam int BIT_SEQ_DONE = 8;

   localparam logic [CH_W-1:0] BANDGAP_CHANNEL = 4'h6;
   localparam logic [1:0] FMT_INTEGER = 2'h0;
   localparam logic [1:0] FMT_SIGNED_INTEGER = 2'h1;
   localparam logic [1:0] FMT_FRACTION = 2'h2;

   typedef enum logic {ST_IDLE, ST_CONVERT} adcsq_state_e;
endpackage

// ==== bench/adcsq_checker_sva.sv ====
`timescale 1ns/1ps
module adcsq_checker #(
   parameter int TCY_CLKS = 2
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcsq_pkg::ADDR_W-1:0] paddr,
   input wire logic [adcsq_pkg::DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic refPosExternal,
   input wire logic refNegExternal,
   input wire logic inputsGrounded,
   input wire logic [adcsq_pkg::CH_W-1:0] muxPosChannel,
   input wire logic muxNegAn1,
   input wire logic bandgapToConverter,
   input wire logic convClkFromRc,
   input wire logic sampleStart,
   input wire logic adcInterrupt
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of written controls; sequences started since the last interrupt
   logic [15:0] ctl2Q;
   logic rcQ;
   logic bgQ;
   logic [4:0] seqQ;
   logic commit;
   assign commit = psel & penable & pready & pwrite;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctl2Q <= 16'h0000;
         rcQ <= 1'b0;
         bgQ <= 1'b0;
         seqQ <= 5'h00;
      end else begin
         if (commit && paddr == adcsq_pkg::OFS_CONTROL_TWO) begin
            ctl2Q <= pwdata[15:0];
         end
         if (commit && paddr == adcsq_pkg::OFS_TIMING_CONTROL) begin
            rcQ <= pwdata[15];
         end
         if (commit && paddr == adcsq_pkg::OFS_ANALOG_INPUT_CONFIG) begin
            bgQ <= pwdata[0];
         end
         seqQ <= adcInterrupt ? 5'h00 : seqQ + {4'h0, sampleStart};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   ref_pos_a: assert property (refPosExternal == (!$past(ctl2Q[15]) && $past(ctl2Q[13])))
      else $error("positive reference select wrong");
   ref_neg_a: assert property (refNegExternal == (!$past(ctl2Q[15]) && $past(ctl2Q[14])))
      else $error("negative reference select wrong");
   cal_ground_a: assert property (inputsGrounded == $past(ctl2Q[12]))
      else $error("calibration grounding wrong");
   cal_mux_a: assert property (inputsGrounded && $past(inputsGrounded) |->
      muxPosChannel == 4'h0 && !muxNegAn1 && !bandgapToConverter)
      else $error("channel switch closed in calibration");
   clk_source_a: assert property (convClkFromRc == $past(rcQ))
      else $error("conversion clock source wrong");
   bandgap_gate_a: assert property (bandgapToConverter |-> $past(bgQ) && !inputsGrounded)
      else $error("band gap offered while disabled");
   irq_count_a: assert property (adcInterrupt |-> seqQ == {1'b0, ctl2Q[5:2]} + 5'h01)
      else $error("interrupt after wrong sequence count");
   start_pulse_a: assert property (sampleStart |=> !sampleStart)
      else $error("sample start longer than one cycle");
endmodule

// ==== bench/adcsq_analog_model.sv ====
`timescale 1ns/1ps
module adcsq_analog_model #(
   parameter int CONV_CLKS = 10
) (
   input wire logic clk_sys,
   input wire logic sampleStart,
   input wire logic inputsGrounded,
   input wire logic [3:0] muxPosChannel,
   output logic rcClockPin,
   output logic convDonePin,
   output logic [9:0] convResult
);
   logic [9:0] level;
   // free-running oscillator, phase unrelated to the system clock
   initial begin
      rcClockPin = 1'b0;
      forever #333 rcClockPin = ~rcClockPin;
   end
   // each channel converts to its own code; grounded inputs give zero
   initial begin
      convDonePin = 1'b0;
      convResult = 10'h3FF;
      forever begin
         @(posedge clk_sys);
         if (sampleStart === 1'b1) begin
            level = inputsGrounded ? 10'h000 : {muxPosChannel, 6'h15};
            repeat (CONV_CLKS) @(posedge clk_sys);
            convResult <= level;
            convDonePin <= 1'b1;
            repeat (8) @(posedge clk_sys);
            convDonePin <= 1'b0;
            convResult <= ~level;
         end
      end
   end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   localparam int INSTRUCTION_CYCLE_PERIOD = 2;
   typedef struct packed {
      logic [7:0] a;
      logic [15:0] w;
      logic [15:0] r;
      logic e;
      logic [1:0] rf;
   } adcsq_row_s;
   logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err, chargePumpEnable;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rcClockPin, convDonePin, refPosExternal, refNegExternal, inputsGrounded, muxNegAn1;
   logic bandgapToConverter, convClkFromRc, convClkTick, sampleStart, adcInterrupt;
   logic [9:0] convResult;
   logic [3:0] muxPosChannel;
   int errorCnt, checks, cycles, irqCnt, n0;
   longint t0;
   adcsq_row_s rows[14];
   adcsq_top #(.TCY_CLKS(INSTRUCTION_CYCLE_PERIOD)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .rcClockPin(rcClockPin), .convDonePin(convDonePin),
      .convResult(convResult), .refPosExternal(refPosExternal), .refNegExternal(refNegExternal),
      .inputsGrounded(inputsGrounded), .muxPosChannel(muxPosChannel), .muxNegAn1(muxNegAn1),
      .bandgapToConverter(bandgapToConverter), .chargePumpEnable(chargePumpEnable),
      .convClkFromRc(convClkFromRc),
      .convClkTick(convClkTick), .sampleStart(sampleStart), .adcInterrupt(adcInterrupt));
   adcsq_analog_model u_model (.clk_sys(clk_sys), .sampleStart(sampleStart),
      .inputsGrounded(inputsGrounded), .muxPosChannel(muxPosChannel), .rcClockPin(rcClockPin),
      .convDonePin(convDonePin), .convResult(convResult));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (adcInterrupt === 1'b1) irqCnt++;
      if (cycles == 20000) begin
         errorCnt++;
         end_of_test();
      end
   end
   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(input logic got, input logic exp);
      cmpVal({31'h0, got}, {31'h0, exp});
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 16'h0000);
      cmpVal(rd, exp);
   endtask
   // start one sequence, poll until it completes, clear the completion flag
   task automatic runSeq();
      int n;
      n = 0;
      rd = 32'h0;
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_ONE, 16'h8001);
      while (rd[8] !== 1'b1 && n < 40) begin
         xfer(1'b0, adcsq_pkg::OFS_STATUS, 16'h0000);
         n++;
      end
      xfer(1'b1, adcsq_pkg::OFS_STATUS, 16'h0100);
   endtask
   task automatic waitTick();
      int n;
      n = 0;
      do @(posedge clk_sys); while (convClkTick !== 1'b1 && n++ < 400);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {errorCnt, checks, cycles, irqCnt} = '0;
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      for (int k = 0; k < 8; k++) begin
         rows[k] = '{adcsq_pkg::OFS_CONTROL_TWO, 16'(k << 13), 16'(k << 13), 1'b0,
            {~k[2] & k[0], ~k[2] & k[1]}};
      end
      rows[8] = '{adcsq_pkg::OFS_TIMING_CONTROL, 16'hFFFF, 16'hBF3F, 1'b0, 2'b00};
      rows[9] = '{adcsq_pkg::OFS_CHANNEL_SELECT, 16'hFFFF, 16'h8F8F, 1'b0, 2'b00};
      rows[10] = '{adcsq_pkg::OFS_SCAN_SELECT, 16'hFFFF, 16'hFFDF, 1'b0, 2'b00};
      rows[11] = '{adcsq_pkg::OFS_ANALOG_INPUT_CONFIG, 16'hFFFF, 16'h0001, 1'b0, 2'b00};
      rows[12] = '{adcsq_pkg::OFS_CONTROL_TWO, 16'h0BC2, 16'h0000, 1'b0, 2'b00};
      rows[13] = '{8'h40, 16'h1234, 16'h0000, 1'b1, 2'b00};
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         xfer(1'b1, rows[i].a, rows[i].w);
         rdChk(rows[i].a, {16'h0000, rows[i].r});
         cmpBit(err, rows[i].e);
         cmpBit(refPosExternal, rows[i].rf[1]);
         cmpBit(refNegExternal, rows[i].rf[0]);
      end
      cmpBit(chargePumpEnable, 1'b1);
      $display("test table done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int k = 1; k < 6; k++) rdChk(8'(k * 4), 32'h0);
      cmpBit(chargePumpEnable, 1'b0);
      $display("test reset done");
      xfer(1'b1, adcsq_pkg::OFS_CHANNEL_SELECT, 16'h0083);
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_TWO, 16'h1000);
      runSeq();
      cmpBit(inputsGrounded, 1'b1);
      cmpVal({28'h0, muxPosChannel}, 32'h0);
      cmpBit(muxNegAn1, 1'b0);
      rdChk(adcsq_pkg::OFS_RESULT_ZERO, 32'h0);
      $display("test calibration done");
      xfer(1'b1, adcsq_pkg::OFS_SCAN_SELECT, 16'h0224);
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_TWO, 16'h0404);
      n0 = irqCnt;
      for (int k = 0; k < 2; k++) begin
         runSeq();
         cmpVal(irqCnt - n0, k);
         runSeq();
         cmpVal(irqCnt - n0, k + 1);
         rdChk(adcsq_pkg::OFS_RESULT_ZERO, {22'h0, 4'h2, 6'h15});
         rdChk(adcsq_pkg::OFS_RESULT_ONE, {22'h0, 4'h9, 6'h15});
      end
      $display("test scan done");
      xfer(1'b1, adcsq_pkg::OFS_CHANNEL_SELECT, 16'h0C04);
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_TWO, 16'h0005);
      runSeq();
      runSeq();
      rdChk(adcsq_pkg::OFS_RESULT_ZERO, {22'h0, 4'h4, 6'h15});
      rdChk(adcsq_pkg::OFS_RESULT_ONE, {22'h0, 4'hC, 6'h15});
      // alignments of word 0 (code 115h) and word 1 (code 315h)
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_ONE, 16'h8100);
      rdChk(adcsq_pkg::OFS_RESULT_ZERO, 32'h0000FF15);
      rdChk(adcsq_pkg::OFS_RESULT_ONE, 32'h00000115);
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_ONE, 16'h8200);
      rdChk(adcsq_pkg::OFS_RESULT_ZERO, 32'h00004540);
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_ONE, 16'h8300);
      rdChk(adcsq_pkg::OFS_RESULT_ZERO, 32'h0000C540);
      $display("test alternate done");
      xfer(1'b1, adcsq_pkg::OFS_TIMING_CONTROL, 16'h0003);
      waitTick();
      waitTick();
      t0 = $time;
      waitTick();
      cmpVal(32'(($time - t0) / 50), INSTRUCTION_CYCLE_PERIOD * 4);
      cmpBit(convClkFromRc, 1'b0);
      xfer(1'b1, adcsq_pkg::OFS_TIMING_CONTROL, 16'h8000);
      waitTick();
      t0 = $time;
      waitTick();
      cmpBit(($time - t0) / 50 > 10, 1'b1);
      cmpBit(convClkFromRc, 1'b1);
      $display("test clock done");
      xfer(1'b1, adcsq_pkg::OFS_CONTROL_TWO, 16'h0000);
      xfer(1'b1, adcsq_pkg::OFS_CHANNEL_SELECT, 16'h0006);
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, adcsq_pkg::OFS_ANALOG_INPUT_CONFIG, 16'(k));
         repeat (3) @(posedge clk_sys);
         cmpBit(bandgapToConverter, k[0]);
      end
      $display("test band gap done");
      end_of_test();
   end
endmodule
bind adcsq_top adcsq_checker #(.TCY_CLKS(TCY_CLKS)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .refPosExternal(refPosExternal), .refNegExternal(refNegExternal),
   .inputsGrounded(inputsGrounded), .muxPosChannel(muxPosChannel), .muxNegAn1(muxNegAn1),
   .bandgapToConverter(bandgapToConverter), .convClkFromRc(convClkFromRc),
   .sampleStart(sampleStart), .adcInterrupt(adcInterrupt));
